// ### core/icd_decoder.sv
// instruction class decoder: classifies each instruction and reports its encoded length
//
// Function
// - add forms take word or byte, optional carry, 2 or 4 bytes
// - subtract forms take word or byte, optional borrow, 2 or 4 bytes
// - product multiplies two general registers 16x16, signed or unsigned, 2 bytes
// - quotient divides multiply_divide_low by a general register 16/16, signed option
// - long quotient divides the 32-bit pair by a 16-bit register, signed option
// - ones and twos complement act in place on word/byte register, 2 bytes
// - bit copy moves a bit, optionally inverted; bit logic/compare are 4 bytes
// - masked field modify alters high or low byte under mask, 4 bytes
// - compare-then-decrement lowers the register by 1 or 2 per variant
// - compare-then-increment raises the register by 1 or 2 per variant
// - normalize count writes shift count into another word register, 2 bytes
// - arithmetic right shift replicates the sign bit, 2 bytes
// - byte widen move sign- or zero-extends, 2 or 4 bytes
// - conditional jumps are taken only when the condition holds, 4 bytes
// - bit branches jump on set (opt. clear) or clear (opt. set), 4 bytes
// - far subroutine call reaches any code segment, 4 bytes
// - push-and-call pushes a register then far_subroutine_call, 4 bytes
// - context switch push saves then reloads a register, 4 bytes
// - software trap enters a routine chosen by immediate number, 2 bytes
// - intra-segment return optionally pops a register, 2 bytes
// - power-down entry acts only while the interrupt pin is held low, 4 bytes
// - every coprocessor multiply-accumulate instruction uses 4 bytes
`timescale 1ns/1ps

module icd_decoder (
    input wire logic clock,                  // cpu clock, 100 MHz
    input wire logic rst,                    // asynchronous reset, active high
    input wire icd_pkg::icd_instr_s instr_i, // instruction from fetch, same clock
    input wire logic nmi_n_pin,              // non-maskable interrupt pin, active low
    output icd_pkg::icd_dec_s dec_o,         // registered decode result
    output logic nmi_low_o                   // filtered pin level, high while pin is low
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] op_len(input icd_pkg::icd_op_e op, input logic long_form);
        logic [2:0] len;
        len = icd_pkg::ICD_LEN_LONG;
        case (op)
            icd_pkg::ICD_OP_ADD, icd_pkg::ICD_OP_ADD_WITH_CARRY, icd_pkg::ICD_OP_SUB,
            icd_pkg::ICD_OP_SUBTRACT_WITH_BORROW, icd_pkg::ICD_OP_LOGIC, icd_pkg::ICD_OP_COMPARE,
            icd_pkg::ICD_OP_COMPARE_THEN_DECREMENT, icd_pkg::ICD_OP_COMPARE_THEN_INCREMENT,
            icd_pkg::ICD_OP_MOVE, icd_pkg::ICD_OP_BYTE_WIDEN_MOVE, icd_pkg::ICD_OP_PAGE_PREFIX,
            icd_pkg::ICD_OP_SEGMENT_PREFIX: begin
                len = long_form ? icd_pkg::ICD_LEN_LONG : icd_pkg::ICD_LEN_SHORT;
            end
            icd_pkg::ICD_OP_PRODUCT, icd_pkg::ICD_OP_QUOTIENT, icd_pkg::ICD_OP_LONG_QUOTIENT,
            icd_pkg::ICD_OP_ONES_COMPLEMENT, icd_pkg::ICD_OP_TWOS_COMPLEMENT,
            icd_pkg::ICD_OP_BIT_SET_CLEAR, icd_pkg::ICD_OP_NORMALIZE_COUNT,
            icd_pkg::ICD_OP_SHIFT_ROTATE, icd_pkg::ICD_OP_ARITH_RIGHT_SHIFT,
            icd_pkg::ICD_OP_SOFTWARE_TRAP, icd_pkg::ICD_OP_PUSH_POP,
            icd_pkg::ICD_OP_INTRA_SEGMENT_RETURN, icd_pkg::ICD_OP_INTER_SEGMENT_RETURN,
            icd_pkg::ICD_OP_INTERRUPT_RETURN, icd_pkg::ICD_OP_SOFTWARE_BREAK,
            icd_pkg::ICD_OP_ATOMIC_PREFIX, icd_pkg::ICD_OP_REGISTER_PREFIX, icd_pkg::ICD_OP_NULL: begin
                len = icd_pkg::ICD_LEN_SHORT;
            end
            default: begin
                len = icd_pkg::ICD_LEN_LONG;
            end
        endcase
        return len;
    endfunction

    function automatic icd_pkg::icd_cls_e op_class(input icd_pkg::icd_op_e op);
        icd_pkg::icd_cls_e c;
        c = icd_pkg::ICD_CLS_ILLEGAL;
        case (op)
            icd_pkg::ICD_OP_ADD, icd_pkg::ICD_OP_ADD_WITH_CARRY, icd_pkg::ICD_OP_SUB,
            icd_pkg::ICD_OP_SUBTRACT_WITH_BORROW, icd_pkg::ICD_OP_ONES_COMPLEMENT,
            icd_pkg::ICD_OP_TWOS_COMPLEMENT, icd_pkg::ICD_OP_NORMALIZE_COUNT: c = icd_pkg::ICD_CLS_ARITH;
            icd_pkg::ICD_OP_PRODUCT, icd_pkg::ICD_OP_QUOTIENT,
            icd_pkg::ICD_OP_LONG_QUOTIENT: c = icd_pkg::ICD_CLS_MULDIV;
            icd_pkg::ICD_OP_LOGIC: c = icd_pkg::ICD_CLS_LOGIC;
            icd_pkg::ICD_OP_BIT_SET_CLEAR, icd_pkg::ICD_OP_BIT_COPY, icd_pkg::ICD_OP_BIT_LOGIC,
            icd_pkg::ICD_OP_BIT_COMPARE, icd_pkg::ICD_OP_MASKED_BYTE_FIELD: c = icd_pkg::ICD_CLS_BIT;
            icd_pkg::ICD_OP_COMPARE, icd_pkg::ICD_OP_COMPARE_THEN_DECREMENT,
            icd_pkg::ICD_OP_COMPARE_THEN_INCREMENT: c = icd_pkg::ICD_CLS_COMPARE;
            icd_pkg::ICD_OP_SHIFT_ROTATE, icd_pkg::ICD_OP_ARITH_RIGHT_SHIFT: c = icd_pkg::ICD_CLS_SHIFT;
            icd_pkg::ICD_OP_MOVE, icd_pkg::ICD_OP_BYTE_WIDEN_MOVE: c = icd_pkg::ICD_CLS_MOVE;
            icd_pkg::ICD_OP_CONDITIONAL_JUMP, icd_pkg::ICD_OP_SEGMENT_JUMP,
            icd_pkg::ICD_OP_BRANCH_ON_BIT_SET, icd_pkg::ICD_OP_BRANCH_ON_BIT_CLEAR: c = icd_pkg::ICD_CLS_JUMP;
            icd_pkg::ICD_OP_CONDITIONAL_CALL, icd_pkg::ICD_OP_FAR_SUBROUTINE_CALL,
            icd_pkg::ICD_OP_PUSH_AND_CALL, icd_pkg::ICD_OP_SOFTWARE_TRAP: c = icd_pkg::ICD_CLS_CALL;
            icd_pkg::ICD_OP_INTRA_SEGMENT_RETURN, icd_pkg::ICD_OP_INTER_SEGMENT_RETURN,
            icd_pkg::ICD_OP_INTERRUPT_RETURN: c = icd_pkg::ICD_CLS_RETURN;
            icd_pkg::ICD_OP_PUSH_POP, icd_pkg::ICD_OP_CONTEXT_SWITCH_PUSH: c = icd_pkg::ICD_CLS_STACK;
            icd_pkg::ICD_OP_SOFTWARE_BREAK, icd_pkg::ICD_OP_SOFTWARE_RESET, icd_pkg::ICD_OP_IDLE_ENTRY,
            icd_pkg::ICD_OP_POWER_DOWN_ENTRY, icd_pkg::ICD_OP_WATCHDOG_SERVICE,
            icd_pkg::ICD_OP_WATCHDOG_ENABLE_CTL, icd_pkg::ICD_OP_INIT_LOCK: c = icd_pkg::ICD_CLS_SYSTEM;
            icd_pkg::ICD_OP_ATOMIC_PREFIX, icd_pkg::ICD_OP_REGISTER_PREFIX, icd_pkg::ICD_OP_PAGE_PREFIX,
            icd_pkg::ICD_OP_SEGMENT_PREFIX: c = icd_pkg::ICD_CLS_PREFIX;
            icd_pkg::ICD_OP_NULL: c = icd_pkg::ICD_CLS_NONE;
            icd_pkg::ICD_OP_COPROC_MAC, icd_pkg::ICD_OP_ACCUMULATOR_LOAD_STORE: c = icd_pkg::ICD_CLS_COPROC;
            default: c = icd_pkg::ICD_CLS_ILLEGAL;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // pin filter: three stages, level accepted when stages two and three agree
    // ------------------------------------------------------------
    logic [2:0] nmi_sync_q;
    logic [2:0] nmi_sync_d;
    logic nmi_low_q;
    logic nmi_low_d;

    always_comb begin
        nmi_sync_d = {nmi_sync_q[1:0], ~nmi_n_pin};
        nmi_low_d = (nmi_sync_q[1] == nmi_sync_q[2]) ? nmi_sync_q[2] : nmi_low_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nmi_sync_q <= 3'h0;
            nmi_low_q <= 1'b0;
        end else begin
            nmi_sync_q <= nmi_sync_d;
            nmi_low_q <= nmi_low_d;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    icd_pkg::icd_dec_s dec_q;
    icd_pkg::icd_dec_s dec_d;

    always_comb begin
        dec_d = '0;
        if (instr_i.valid) begin
            dec_d.valid = 1'b1;
            dec_d.cls = op_class(instr_i.op);
            dec_d.length = op_len(instr_i.op, instr_i.long_form);
            dec_d.byte_size = instr_i.byte_op;
            case (instr_i.op)
                icd_pkg::ICD_OP_ADD_WITH_CARRY, icd_pkg::ICD_OP_SUBTRACT_WITH_BORROW: begin
                    dec_d.use_carry = 1'b1;
                end
                icd_pkg::ICD_OP_PRODUCT, icd_pkg::ICD_OP_QUOTIENT, icd_pkg::ICD_OP_LONG_QUOTIENT: begin
                    // dividers and multiplier are always word wide
                    dec_d.byte_size = 1'b0;
                    dec_d.signed_op = instr_i.signed_op;
                end
                icd_pkg::ICD_OP_BIT_COPY: begin
                    dec_d.bit_invert = instr_i.alt;
                end
                icd_pkg::ICD_OP_MASKED_BYTE_FIELD: begin
                    dec_d.high_byte = instr_i.alt;
                end
                icd_pkg::ICD_OP_COMPARE_THEN_DECREMENT, icd_pkg::ICD_OP_COMPARE_THEN_INCREMENT: begin
                    dec_d.byte_size = 1'b0;
                    dec_d.step_down = (instr_i.op == icd_pkg::ICD_OP_COMPARE_THEN_DECREMENT);
                    dec_d.step_amt = instr_i.alt ? icd_pkg::ICD_STEP_TWO : icd_pkg::ICD_STEP_ONE;
                end
                icd_pkg::ICD_OP_NORMALIZE_COUNT, icd_pkg::ICD_OP_ARITH_RIGHT_SHIFT: begin
                    dec_d.byte_size = 1'b0;
                    dec_d.sign_extend = (instr_i.op == icd_pkg::ICD_OP_ARITH_RIGHT_SHIFT);
                end
                icd_pkg::ICD_OP_BYTE_WIDEN_MOVE: begin
                    dec_d.byte_size = 1'b1;
                    dec_d.sign_extend = instr_i.signed_op;
                end
                icd_pkg::ICD_OP_CONDITIONAL_JUMP, icd_pkg::ICD_OP_CONDITIONAL_CALL: begin
                    dec_d.taken = instr_i.cond_met;
                end
                icd_pkg::ICD_OP_SEGMENT_JUMP, icd_pkg::ICD_OP_FAR_SUBROUTINE_CALL,
                icd_pkg::ICD_OP_SOFTWARE_TRAP: begin
                    dec_d.taken = 1'b1;
                end
                icd_pkg::ICD_OP_BRANCH_ON_BIT_SET: begin
                    dec_d.taken = instr_i.bit_val;
                    dec_d.bit_write = instr_i.bit_val && instr_i.alt;
                    dec_d.bit_write_val = 1'b0;
                end
                icd_pkg::ICD_OP_BRANCH_ON_BIT_CLEAR: begin
                    dec_d.taken = !instr_i.bit_val;
                    dec_d.bit_write = !instr_i.bit_val && instr_i.alt;
                    dec_d.bit_write_val = 1'b1;
                end
                icd_pkg::ICD_OP_PUSH_AND_CALL, icd_pkg::ICD_OP_CONTEXT_SWITCH_PUSH: begin
                    dec_d.push_first = 1'b1;
                    dec_d.taken = (instr_i.op == icd_pkg::ICD_OP_PUSH_AND_CALL);
                end
                icd_pkg::ICD_OP_INTRA_SEGMENT_RETURN: begin
                    dec_d.pop_reg = instr_i.alt;
                end
                icd_pkg::ICD_OP_POWER_DOWN_ENTRY: begin
                    // with the pin high the request is dropped and the op retires as a no-op
                    dec_d.power_down = nmi_low_q;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dec_q <= '0;
        end else begin
            dec_q <= dec_d;
        end
    end

    assign dec_o = dec_q;
    assign nmi_low_o = nmi_low_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_add_carry;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_ADD_WITH_CARRY |=>
            dec_q.use_carry && dec_q.length == ($past(instr_i.long_form) ? 3'h4 : 3'h2);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add with carry decode wrong");

    property p_sub_borrow;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_SUBTRACT_WITH_BORROW && !instr_i.long_form |=>
            dec_q.use_carry && dec_q.length == 3'h2 && dec_q.cls == icd_pkg::ICD_CLS_ARITH;
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("subtract with borrow decode wrong");

    property p_product;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_PRODUCT |=>
            dec_q.length == 3'h2 && dec_q.signed_op == $past(instr_i.signed_op) && !dec_q.byte_size;
    endproperty
    a_product: assert property (p_product) else $error("product decode wrong");

    property p_complement;
        instr_i.valid && (instr_i.op == icd_pkg::ICD_OP_ONES_COMPLEMENT ||
            instr_i.op == icd_pkg::ICD_OP_TWOS_COMPLEMENT) |=>
            dec_q.length == 3'h2 && dec_q.byte_size == $past(instr_i.byte_op);
    endproperty
    a_complement: assert property (p_complement) else $error("complement decode wrong");

    property p_bit_copy;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_BIT_COPY |=>
            dec_q.length == 3'h4 && dec_q.bit_invert == $past(instr_i.alt);
    endproperty
    a_bit_copy: assert property (p_bit_copy) else $error("bit copy decode wrong");

    property p_decrement_step;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_COMPARE_THEN_DECREMENT ##0 instr_i.alt |=>
            dec_q.step_down && dec_q.step_amt == 2'h2;
    endproperty
    a_decrement_step: assert property (p_decrement_step) else $error("decrement step wrong");

    property p_widen;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_BYTE_WIDEN_MOVE |=>
            dec_q.sign_extend == $past(instr_i.signed_op);
    endproperty
    a_widen: assert property (p_widen) else $error("widen extension wrong");

    property p_jump_cond;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_CONDITIONAL_JUMP && !instr_i.cond_met |=>
            !dec_q.taken && dec_q.length == 3'h4;
    endproperty
    a_jump_cond: assert property (p_jump_cond) else $error("jump taken without condition");

    property p_bit_branch;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_BRANCH_ON_BIT_SET && instr_i.bit_val && instr_i.alt |=>
            dec_q.taken && dec_q.bit_write && !dec_q.bit_write_val;
    endproperty
    a_bit_branch: assert property (p_bit_branch) else $error("bit branch with clear wrong");

    property p_power_down;
        nmi_n_pin [*5] ##0 instr_i.valid && instr_i.op == icd_pkg::ICD_OP_POWER_DOWN_ENTRY |=>
            !dec_q.power_down;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down with pin high");

    property p_coproc;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_ACCUMULATOR_LOAD_STORE |=>
            dec_q.length == 3'h4 && dec_q.cls == icd_pkg::ICD_CLS_COPROC;
    endproperty
    a_coproc: assert property (p_coproc) else $error("coprocessor length wrong");

    property p_long_quotient;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_LONG_QUOTIENT |=>
            dec_q.cls == icd_pkg::ICD_CLS_MULDIV && !dec_q.byte_size &&
            dec_q.signed_op == $past(instr_i.signed_op);
    endproperty
    a_long_quotient: assert property (p_long_quotient) else $error("long quotient decode wrong");

    property p_masked_field;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_MASKED_BYTE_FIELD |=>
            dec_q.length == icd_pkg::ICD_LEN_LONG && dec_q.high_byte == $past(instr_i.alt);
    endproperty
    a_masked_field: assert property (p_masked_field) else $error("masked field decode wrong");

    property p_increment_step;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_COMPARE_THEN_INCREMENT |=>
            !dec_q.step_down &&
            dec_q.step_amt == ($past(instr_i.alt) ? icd_pkg::ICD_STEP_TWO : icd_pkg::ICD_STEP_ONE);
    endproperty
    a_increment_step: assert property (p_increment_step) else $error("increment step wrong");

    property p_arith_shift;
        instr_i.valid && instr_i.op == icd_pkg::ICD_OP_ARITH_RIGHT_SHIFT |=>
            dec_q.sign_extend && !dec_q.byte_size && dec_q.length == icd_pkg::ICD_LEN_SHORT;
    endproperty
    a_arith_shift: assert property (p_arith_shift) else $error("arithmetic shift decode wrong");

endmodule // icd_decoder

// ### core/icd_pkg.sv
// package: opcodes, operation classes and decode carriers for the instruction class decoder
package icd_pkg;

    // ------------------------------------------------------------
    // encoded lengths in bytes and compare-then-step amounts
    // ------------------------------------------------------------
    localparam logic [2:0] ICD_LEN_SHORT = 3'h2;
    localparam logic [2:0] ICD_LEN_LONG = 3'h4;
    localparam logic [1:0] ICD_STEP_ONE = 2'h1;
    localparam logic [1:0] ICD_STEP_TWO = 2'h2;

    // ------------------------------------------------------------
    // operation selectors, one per instruction family
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ICD_OP_ADD = 6'h00, ICD_OP_ADD_WITH_CARRY = 6'h01, ICD_OP_SUB = 6'h02,
        ICD_OP_SUBTRACT_WITH_BORROW = 6'h03, ICD_OP_PRODUCT = 6'h04, ICD_OP_QUOTIENT = 6'h05,
        ICD_OP_LONG_QUOTIENT = 6'h06, ICD_OP_ONES_COMPLEMENT = 6'h07, ICD_OP_TWOS_COMPLEMENT = 6'h08,
        ICD_OP_LOGIC = 6'h09, ICD_OP_BIT_SET_CLEAR = 6'h0a, ICD_OP_BIT_COPY = 6'h0b,
        ICD_OP_BIT_LOGIC = 6'h0c, ICD_OP_BIT_COMPARE = 6'h0d, ICD_OP_MASKED_BYTE_FIELD = 6'h0e,
        ICD_OP_COMPARE = 6'h0f, ICD_OP_COMPARE_THEN_DECREMENT = 6'h10,
        ICD_OP_COMPARE_THEN_INCREMENT = 6'h11, ICD_OP_NORMALIZE_COUNT = 6'h12,
        ICD_OP_SHIFT_ROTATE = 6'h13, ICD_OP_ARITH_RIGHT_SHIFT = 6'h14, ICD_OP_MOVE = 6'h15,
        ICD_OP_BYTE_WIDEN_MOVE = 6'h16, ICD_OP_CONDITIONAL_JUMP = 6'h17, ICD_OP_SEGMENT_JUMP = 6'h18,
        ICD_OP_BRANCH_ON_BIT_SET = 6'h19, ICD_OP_BRANCH_ON_BIT_CLEAR = 6'h1a,
        ICD_OP_CONDITIONAL_CALL = 6'h1b, ICD_OP_FAR_SUBROUTINE_CALL = 6'h1c, ICD_OP_PUSH_AND_CALL = 6'h1d,
        ICD_OP_SOFTWARE_TRAP = 6'h1e, ICD_OP_PUSH_POP = 6'h1f, ICD_OP_CONTEXT_SWITCH_PUSH = 6'h20,
        ICD_OP_INTRA_SEGMENT_RETURN = 6'h21, ICD_OP_INTER_SEGMENT_RETURN = 6'h22,
        ICD_OP_INTERRUPT_RETURN = 6'h23, ICD_OP_SOFTWARE_BREAK = 6'h24, ICD_OP_SOFTWARE_RESET = 6'h25,
        ICD_OP_IDLE_ENTRY = 6'h26, ICD_OP_POWER_DOWN_ENTRY = 6'h27, ICD_OP_WATCHDOG_SERVICE = 6'h28,
        ICD_OP_WATCHDOG_ENABLE_CTL = 6'h29, ICD_OP_INIT_LOCK = 6'h2a, ICD_OP_ATOMIC_PREFIX = 6'h2b,
        ICD_OP_REGISTER_PREFIX = 6'h2c, ICD_OP_PAGE_PREFIX = 6'h2d, ICD_OP_SEGMENT_PREFIX = 6'h2e,
        ICD_OP_NULL = 6'h2f, ICD_OP_COPROC_MAC = 6'h30, ICD_OP_ACCUMULATOR_LOAD_STORE = 6'h31
    } icd_op_e;

    typedef enum logic [3:0] {
        ICD_CLS_NONE = 4'h0, ICD_CLS_ARITH = 4'h1, ICD_CLS_MULDIV = 4'h2, ICD_CLS_LOGIC = 4'h3,
        ICD_CLS_BIT = 4'h4, ICD_CLS_COMPARE = 4'h5, ICD_CLS_SHIFT = 4'h6, ICD_CLS_MOVE = 4'h7,
        ICD_CLS_JUMP = 4'h8, ICD_CLS_CALL = 4'h9, ICD_CLS_RETURN = 4'ha, ICD_CLS_STACK = 4'hb,
        ICD_CLS_SYSTEM = 4'hc, ICD_CLS_PREFIX = 4'hd, ICD_CLS_COPROC = 4'he, ICD_CLS_ILLEGAL = 4'hf
    } icd_cls_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;        // instruction present this cycle
        icd_op_e op;        // operation selector
        logic byte_op;      // byte operand size
        logic signed_op;    // signed variant / sign extension
        logic long_form;    // 4-byte form where both forms exist
        logic alt;          // second variant: step by 2, inverted, modify bit, high byte, pop register
        logic cond_met;     // condition code evaluated true
        logic bit_val;      // current value of tested bit
    } icd_instr_s;

    typedef struct packed {
        logic valid;
        icd_cls_e cls;
        logic [2:0] length;
        logic byte_size;
        logic signed_op;
        logic use_carry;
        logic bit_invert;
        logic high_byte;
        logic step_down;
        logic [1:0] step_amt;
        logic sign_extend;
        logic taken;
        logic bit_write;
        logic bit_write_val;
        logic push_first;
        logic pop_reg;
        logic power_down;
    } icd_dec_s;

endpackage

// ### verif/icd_decoder_tb.sv
// self-checking testbench for the instruction class decoder
`timescale 1ns/1ps

module instruction_class_decoder_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    icd_pkg::icd_instr_s instr = '0;
    logic nmi_n_pin = 1'b1;
    icd_pkg::icd_dec_s dec_o;
    logic nmi_low_o;
    int mismatches = 0;
    int cmp_count = 0;

    icd_decoder icd_decoder_inst (
        .clock(clock),
        .rst(rst),
        .instr_i(instr),
        .nmi_n_pin(nmi_n_pin),
        .dec_o(dec_o),
        .nmi_low_o(nmi_low_o)
    );

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // -------------------------------------------------------
    // drivers
    // -------------------------------------------------------
    // flags: byte, signed, long, alt, cond, bit value; result checked 1 ns after the taking edge
    task automatic drive(input icd_pkg::icd_op_e op, input logic [5:0] f);
        @(negedge clock);
        instr = {1'b1, op, f};
        @(posedge clock);
        #1;
        chk("valid", 8'(dec_o.valid), 8'h01);
    endtask

    task automatic t_arith();
        icd_pkg::icd_op_e ops[4] = '{icd_pkg::ICD_OP_ADD, icd_pkg::ICD_OP_ADD_WITH_CARRY, icd_pkg::ICD_OP_SUB,
                                     icd_pkg::ICD_OP_SUBTRACT_WITH_BORROW};
        for (int k = 0; k < 16; k++) begin
            drive(ops[k%4], {k[2], 1'b0, k[3], 3'b000});
            chk("arith_cls", 8'(dec_o.cls), 8'(icd_pkg::ICD_CLS_ARITH));
            chk("arith_byte", 8'(dec_o.byte_size), 8'(k[2]));
            chk("arith_carry", 8'(dec_o.use_carry), 8'(k[0]));
            chk("arith_len", 8'(dec_o.length), k[3] ? 8'(icd_pkg::ICD_LEN_LONG) : 8'(icd_pkg::ICD_LEN_SHORT));
        end
    endtask

    task automatic t_muldiv();
        icd_pkg::icd_op_e ops[3] = '{icd_pkg::ICD_OP_PRODUCT, icd_pkg::ICD_OP_QUOTIENT,
                                     icd_pkg::ICD_OP_LONG_QUOTIENT};
        for (int k = 0; k < 6; k++) begin
            drive(ops[k/2], {1'b1, k[0], 4'b0000});
            chk("md_cls", 8'(dec_o.cls), 8'(icd_pkg::ICD_CLS_MULDIV));
            chk("md_signed", 8'(dec_o.signed_op), 8'(k[0]));
            chk("md_byte", 8'(dec_o.byte_size), 8'h00);
            chk("md_len", 8'(dec_o.length), 8'(icd_pkg::ICD_LEN_SHORT));
        end
    endtask

    task automatic t_fixed();
        icd_pkg::icd_op_e ops[15] = '{icd_pkg::ICD_OP_ONES_COMPLEMENT, icd_pkg::ICD_OP_TWOS_COMPLEMENT,
            icd_pkg::ICD_OP_BIT_COPY, icd_pkg::ICD_OP_BIT_LOGIC, icd_pkg::ICD_OP_BIT_COMPARE,
            icd_pkg::ICD_OP_MASKED_BYTE_FIELD, icd_pkg::ICD_OP_NORMALIZE_COUNT, icd_pkg::ICD_OP_ARITH_RIGHT_SHIFT,
            icd_pkg::ICD_OP_FAR_SUBROUTINE_CALL, icd_pkg::ICD_OP_PUSH_AND_CALL, icd_pkg::ICD_OP_CONTEXT_SWITCH_PUSH,
            icd_pkg::ICD_OP_SOFTWARE_TRAP, icd_pkg::ICD_OP_INTRA_SEGMENT_RETURN, icd_pkg::ICD_OP_COPROC_MAC,
            icd_pkg::ICD_OP_ACCUMULATOR_LOAD_STORE};
        bit lm[15] = '{0, 0, 1, 1, 1, 1, 0, 0, 1, 1, 1, 0, 0, 1, 1};
        for (int a = 0; a < 2; a++) begin
            // long_form held opposite to the fixed length so a decoder that trusts it is caught
            for (int i = 0; i < 15; i++) begin
                drive(ops[i], {2'b00, ~lm[i], a[0], 2'b00});
                chk("fix_len", 8'(dec_o.length), lm[i] ? 8'h04 : 8'h02);
                case (ops[i])
                    icd_pkg::ICD_OP_BIT_COPY: chk("invert", 8'(dec_o.bit_invert), 8'(a));
                    icd_pkg::ICD_OP_MASKED_BYTE_FIELD: chk("high_byte", 8'(dec_o.high_byte), 8'(a));
                    icd_pkg::ICD_OP_INTRA_SEGMENT_RETURN: chk("pop_reg", 8'(dec_o.pop_reg), 8'(a));
                    icd_pkg::ICD_OP_PUSH_AND_CALL: chk("push_and_call", {dec_o.push_first, dec_o.taken}, 8'h03);
                    icd_pkg::ICD_OP_CONTEXT_SWITCH_PUSH: chk("cswitch", 8'(dec_o.push_first), 8'h01);
                    default: ;
                endcase
            end
        end
    endtask

    task automatic t_step_widen();
        for (int k = 0; k < 4; k++) begin
            drive(k[1] ? icd_pkg::ICD_OP_COMPARE_THEN_INCREMENT : icd_pkg::ICD_OP_COMPARE_THEN_DECREMENT,
                  {3'b000, k[0], 2'b00});
            chk("step_down", 8'(dec_o.step_down), 8'(!k[1]));
            chk("step_amt", 8'(dec_o.step_amt), k[0] ? 8'(icd_pkg::ICD_STEP_TWO) : 8'(icd_pkg::ICD_STEP_ONE));
            drive(icd_pkg::ICD_OP_BYTE_WIDEN_MOVE, {1'b1, k[0], k[1], 3'b000});
            chk("sign_ext", 8'(dec_o.sign_extend), 8'(k[0]));
            chk("widen_len", 8'(dec_o.length), k[1] ? 8'h04 : 8'h02);
        end
    endtask

    task automatic t_branch();
        for (int k = 0; k < 8; k++) begin
            drive(icd_pkg::ICD_OP_CONDITIONAL_JUMP, {3'b000, 1'b0, k[0], 1'b0});
            chk("jmp_taken", 8'(dec_o.taken), 8'(k[0]));
            chk("jmp_len", 8'(dec_o.length), 8'h04);
            drive(k[2] ? icd_pkg::ICD_OP_BRANCH_ON_BIT_CLEAR : icd_pkg::ICD_OP_BRANCH_ON_BIT_SET,
                  {3'b000, k[1], 1'b0, k[0]});
            chk("jb_taken", 8'(dec_o.taken), 8'(k[2] ^ k[0]));
            chk("jb_write", 8'(dec_o.bit_write), 8'((k[2] ^ k[0]) & k[1]));
            if ((k[2] ^ k[0]) & k[1]) chk("jb_wval", 8'(dec_o.bit_write_val), 8'(k[2]));
            chk("jb_len", 8'(dec_o.length), 8'h04);
        end
    endtask

    task automatic t_others();
        icd_pkg::icd_op_e ops[21] = '{icd_pkg::ICD_OP_LOGIC, icd_pkg::ICD_OP_COMPARE, icd_pkg::ICD_OP_MOVE,
            icd_pkg::ICD_OP_PAGE_PREFIX, icd_pkg::ICD_OP_SEGMENT_PREFIX, icd_pkg::ICD_OP_BIT_SET_CLEAR,
            icd_pkg::ICD_OP_SHIFT_ROTATE, icd_pkg::ICD_OP_PUSH_POP, icd_pkg::ICD_OP_INTER_SEGMENT_RETURN,
            icd_pkg::ICD_OP_INTERRUPT_RETURN, icd_pkg::ICD_OP_SOFTWARE_BREAK, icd_pkg::ICD_OP_ATOMIC_PREFIX,
            icd_pkg::ICD_OP_REGISTER_PREFIX, icd_pkg::ICD_OP_NULL, icd_pkg::ICD_OP_SEGMENT_JUMP,
            icd_pkg::ICD_OP_CONDITIONAL_CALL, icd_pkg::ICD_OP_SOFTWARE_RESET, icd_pkg::ICD_OP_IDLE_ENTRY,
            icd_pkg::ICD_OP_WATCHDOG_SERVICE, icd_pkg::ICD_OP_WATCHDOG_ENABLE_CTL, icd_pkg::ICD_OP_INIT_LOCK};
        // first five take either length, the next nine are short only, the rest long only
        for (int a = 0; a < 2; a++) begin
            for (int i = 0; i < 21; i++) begin
                drive(ops[i], {2'b00, a[0], 3'b000});
                chk("other_len", 8'(dec_o.length), (i < 5) ? (a[0] ? 8'h04 : 8'h02) : ((i < 14) ? 8'h02 : 8'h04));
            end
        end
        // an unassigned selector is reported as illegal and long
        drive(icd_pkg::icd_op_e'(6'h3f), 6'h00);
        chk("illegal_cls", 8'(dec_o.cls), 8'(icd_pkg::ICD_CLS_ILLEGAL));
        chk("illegal_len", 8'(dec_o.length), 8'(icd_pkg::ICD_LEN_LONG));
    endtask

    task automatic t_power();
        int n;
        drive(icd_pkg::ICD_OP_POWER_DOWN_ENTRY, 6'h00);
        chk("pd_pin_high", 8'(dec_o.power_down), 8'h00);
        chk("pd_len", 8'(dec_o.length), 8'h04);
        @(negedge clock);
        instr = '0;
        nmi_n_pin = 1'b0;
        n = 0;
        while (nmi_low_o !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 8) begin
            mismatches++;
            report_and_stop();
        end
        chk("idle_zero", 8'(|dec_o), 8'h00);
        drive(icd_pkg::ICD_OP_POWER_DOWN_ENTRY, 6'h00);
        chk("pd_pin_low", 8'(dec_o.power_down), 8'h01);
        @(negedge clock);
        nmi_n_pin = 1'b1;
        instr = '0;
    endtask

    initial begin
        repeat (6) @(posedge clock);
        #1;
        chk("reset_zero", {7'h00, |dec_o}, 8'h00);
        @(negedge clock);
        rst = 1'b0;
        t_arith();
        t_muldiv();
        t_fixed();
        t_step_widen();
        t_branch();
        t_others();
        t_power();
        report_and_stop();
    end
endmodule // instruction_class_decoder_tb
